/* File: rtl/dlec_pkg.sv */
// constants shared by the deserializer control register bank
// assumes one 40 MHz clock and byte-wide registers behind an SMBus slave

package dlec_pkg;
   // ************************************************************
   // register byte addresses
   // ************************************************************
   localparam logic [7:0] ADDR_DEV_CFG = 8'h21;
   localparam logic [7:0] ADDR_UNLOCK = 8'h22;
   localparam logic [7:0] ADDR_LANE_EN = 8'h27;
   localparam logic [7:0] ADDR_CLK_CFG = 8'h28;
   localparam logic [7:0] ADDR_EVT_CFG = 8'h2B;
   localparam logic [7:0] ADDR_ERR_MON = 8'h2D;
   localparam logic [7:0] ADDR_EVT_STAT = 8'h3D;
   localparam logic [7:0] ADDR_ERR_LSB = 8'h3E;
   localparam logic [7:0] ADDR_ERR_MSB = 8'h3F;
   // reset values and writable-bit masks (reserved bits read zero)
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_CLK_CFG = 8'h28;
   localparam logic [7:0] MASK_DEV_CFG = 8'h7F;
   localparam logic [7:0] MASK_UNLOCK = 8'h77;
   localparam logic [7:0] MASK_LANE_EN = 8'hFF;
   localparam logic [7:0] MASK_CLK_CFG = 8'h7C;
   localparam logic [7:0] MASK_EVT_CFG = 8'h0F;
   localparam logic [7:0] MASK_ERR_MON = 8'h1E;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int CFG_NRZI = 6;
   localparam int CFG_DESCR = 5;
   localparam int CFG_MUX = 4;
   localparam int CFG_BYP = 3;
   localparam int CFG_TRAIN = 2;
   localparam int CFG_LINK_HI = 1;
   localparam int CFG_LINK_LO = 0;
   localparam int UNL_NRZI = 6;
   localparam int UNL_DESCR = 5;
   localparam int UNL_MUX = 4;
   localparam int UNL_BYP = 2;
   localparam int UNL_TRAIN = 1;
   localparam int UNL_LINK = 0;
   localparam int LANE_VOD = 7;
   localparam int LANE_CTRL = 6;
   localparam int LANE_CLK = 5;
   localparam int CLK_RST = 6;
   localparam int CLK_RATE = 5;
   localparam int CLK_INV = 4;
   localparam int CLK_DLY_HI = 3;
   localparam int CLK_DLY_LO = 2;
   localparam int EVT_SEL = 3;
   localparam int EVT_RST_REC = 2;
   localparam int EVT_RST_DATA = 1;
   localparam int EVT_EN = 0;
   localparam int ERR_ACC = 4;
   localparam int ERR_DEC_DIS = 3;
   localparam int ERR_CLR = 2;
   localparam int ERR_SEL = 1;
   // serial bus framing
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [2:0] {
      SMB_IDLE, SMB_ADDR, SMB_REG, SMB_DATA, SMB_SEND, SMB_RACK, SMB_RNEXT
   } dlec_smb_state_t;
endpackage

/* File: rtl/dlec_reg_if.sv */
// register access carrier between the bus slave and the register bank
// assumes both ends run on the same clock

interface dlec_reg_if;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport bus (output wr, output addr, output wdata, input rdata);
   modport regs (input wr, input addr, input wdata, output rdata);
endinterface

/* File: rtl/dlec_smbus_slave.sv */
// SMBus byte-register slave: write pointer then data, or read from pointer
// assumes pins filtered here; SCL is far slower than the 40 MHz clock

module dlec_smbus_slave #(
   parameter logic [6:0] SLAVE_ADDR = 7'h5A
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe,
   // register side
   dlec_reg_if.bus rif
);
   import dlec_pkg::*;
   logic [2:0] scl_s, sda_s, next_scl_s, next_sda_s;
   logic scl_f, sda_f, next_scl_f, next_sda_f;
   dlec_smb_state_t state, next_state;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] shift, next_shift, tx, next_tx, ptr, next_ptr, wdata, next_wdata;
   logic acking, next_acking, oe, next_oe, wr, next_wr;
   logic rise, fall, start, stop;

   // a level counts once the second and third stages agree
   assign next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
   assign next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
   assign rise = ~scl_f & next_scl_f;
   assign fall = scl_f & ~next_scl_f;
   assign start = scl_f & next_scl_f & sda_f & ~next_sda_f;
   assign stop = scl_f & next_scl_f & ~sda_f & next_sda_f;

   // bit engine: sample on rising SCL, change SDA on falling SCL
   always_comb begin
      next_scl_s = {scl_s[1:0], scl_in};
      next_sda_s = {sda_s[1:0], sda_in};
      next_state = state;
      next_bitcnt = bitcnt;
      next_shift = shift;
      next_tx = tx;
      next_ptr = ptr;
      next_wdata = wdata;
      next_acking = acking;
      next_oe = oe;
      next_wr = 1'b0;
      // the pointer steps after a write strobe has used it and on a read byte's master
      // acknowledge; the register byte's own acknowledge leaves the loaded pointer alone
      if (wr) begin
         next_ptr = ptr + 8'h01;
      end
      if (start) begin
         next_state = SMB_ADDR;
         next_bitcnt = 4'h0;
         next_acking = 1'b0;
         next_oe = 1'b0;
      end else if (stop) begin
         next_state = SMB_IDLE;
         next_acking = 1'b0;
         next_oe = 1'b0;
      end else if (rise && state != SMB_IDLE) begin
         next_bitcnt = bitcnt + 4'h1;
         next_shift = {shift[6:0], next_sda_f};
         if (state == SMB_RACK) begin
            next_state = next_sda_f ? SMB_IDLE : SMB_RNEXT;
            if (!next_sda_f) begin
               next_ptr = ptr + 8'h01;
            end
         end
      end else if (fall) begin
         if (acking) begin
            next_acking = 1'b0;
            next_oe = 1'b0;
            next_bitcnt = 4'h0;
            if (state == SMB_SEND) begin
               next_tx = rif.rdata;
               next_oe = ~rif.rdata[7];
            end
         end else if (state == SMB_SEND) begin
            if (bitcnt == BYTE_BITS) begin
               next_oe = 1'b0;
               next_state = SMB_RACK;
            end else begin
               next_oe = ~tx[6];
               next_tx = {tx[6:0], 1'b0};
            end
         end else if (state == SMB_RNEXT) begin
            next_state = SMB_SEND;
            next_bitcnt = 4'h0;
            next_tx = rif.rdata;
            next_oe = ~rif.rdata[7];
         end else if (bitcnt == BYTE_BITS && state != SMB_IDLE) begin
            next_acking = 1'b1;
            next_oe = 1'b1;
            if (state == SMB_ADDR) begin
               if (shift[7:1] != SLAVE_ADDR) begin
                  next_state = SMB_IDLE;
                  next_acking = 1'b0;
                  next_oe = 1'b0;
               end else begin
                  next_state = shift[0] ? SMB_SEND : SMB_REG;
               end
            end else if (state == SMB_REG) begin
               next_ptr = shift;
               next_state = SMB_DATA;
            end else if (state == SMB_DATA) begin
               next_wr = 1'b1;
               next_wdata = shift;
            end
         end
      end
   end

   // registers only; bus lines idle high after reset
   always_ff @(posedge clock) begin
      if (!resetn) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         state <= SMB_IDLE;
         bitcnt <= 4'h0;
         shift <= 8'h00;
         tx <= 8'h00;
         ptr <= 8'h00;
         wdata <= 8'h00;
         acking <= 1'b0;
         oe <= 1'b0;
         wr <= 1'b0;
      end else begin
         scl_s <= next_scl_s;
         sda_s <= next_sda_s;
         scl_f <= next_scl_f;
         sda_f <= next_sda_f;
         state <= next_state;
         bitcnt <= next_bitcnt;
         shift <= next_shift;
         tx <= next_tx;
         ptr <= next_ptr;
         wdata <= next_wdata;
         acking <= next_acking;
         oe <= next_oe;
         wr <= next_wr;
      end
   end

   assign sda_oe = oe;
   assign rif.wr = wr;
   assign rif.addr = ptr;
   assign rif.wdata = wdata;
endmodule

/* File: rtl/dlec_regs.sv */
// deserializer control register bank: unlock gating, output driver
// control, event and error counters, reached over SMBus pins
// assumes event and error inputs are one-cycle pulses on this clock
//
// Operation
// R1 - unlock bits 6,5,4 gate decode, descramble and input select bits
// R2 - unlock bit 2 gates bypass bit 3; unlock bit 1 gates training bit 2
// R3 - unlock bit 0 gates both link configuration bits 1:0
// R4 - a guarded configuration bit is ignored until its unlock bit is set
// R5 - written lane enables apply only while control bit 6 is one
// R6 - bit 5 enables clock driver, bits 4:0 lanes; all reset to zero
// R7 - clock rate bit: 0 half, 1 full double-rate clock; resets to one
// R8 - clock invert bit 4 inverts forwarded clock polarity
// R9 - two-bit delay code, 80 ps steps, 00 is 160 ps, reset 10
// R10 - select bit 3 picks recovery counter at 0, data counter at 1
// R11 - writing one to event bit 2 resets the recovery count
// R12 - writing one to event bit 1 resets the data count
// R13 - event counters advance only while enable bit 0 is set
// R14 - error monitor bit 4 accumulates errors instead of restarting
// R15 - bit 3 drops decode errors from the count and the lock flag
// R16 - clear bit 2 zeroes current and previous error counts
// R17 - select bit 1 reports current run at 0, timing window at 1
// R18 - reset and clear bits hold zero while set, resume from zero

module dlec_regs #(
   parameter int EVT_W = 8,
   parameter int ERR_W = 16,
   parameter logic [6:0] SLAVE_ADDR = 7'h5A
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // management bus pins
   input wire logic smb_scl_in,
   input wire logic smb_sda_in,
   output logic smb_sda_out,
   output logic smb_sda_oe,
   // unlocked configuration controls
   output logic nrzi_decode_en,
   output logic descramble_en,
   output logic input_select,
   output logic decoder_bypass,
   output logic training_en,
   output logic [1:0] link_config,
   // parallel output drivers
   input wire logic [5:0] default_lane_enable,
   output logic forwarded_clock_out_en,
   output logic [4:0] parallel_lane_out_en,
   output logic output_vod_high,
   output logic output_block_reset,
   output logic forwarded_clock_full_rate,
   output logic forwarded_clock_invert,
   output logic [1:0] forwarded_clock_delay,
   // event counters
   input wire logic recovery_event,
   input wire logic data_event,
   output logic [EVT_W-1:0] event_count,
   // error monitor
   input wire logic data_error,
   input wire logic decode_error,
   input wire logic window_end,
   output logic [ERR_W-1:0] error_count,
   output logic lock_decode_flag
);
   import dlec_pkg::*;

   // ************************************************************
   // bus slave
   // ************************************************************
   dlec_reg_if rif ();

   dlec_smbus_slave #(.SLAVE_ADDR(SLAVE_ADDR)) u_slave (
      .clock(clock),
      .resetn(resetn),
      .scl_in(smb_scl_in),
      .sda_in(smb_sda_in),
      .sda_oe(smb_sda_oe),
      .rif(rif)
   );

   // open drain: only ever pulls low
   assign smb_sda_out = 1'b0;

   // ************************************************************
   // register file
   // ************************************************************
   logic [7:0] dev_cfg, unlock, lane_en, clk_cfg, evt_cfg, err_mon;
   logic [7:0] next_dev_cfg, next_unlock, next_lane_en;
   logic [7:0] next_clk_cfg, next_evt_cfg, next_err_mon;

   // writes keep only implemented bits; unmapped writes are dropped
   always_comb begin
      next_dev_cfg = dev_cfg;
      next_unlock = unlock;
      next_lane_en = lane_en;
      next_clk_cfg = clk_cfg;
      next_evt_cfg = evt_cfg;
      next_err_mon = err_mon;
      if (rif.wr) begin
         case (rif.addr)
            ADDR_DEV_CFG: next_dev_cfg = rif.wdata & MASK_DEV_CFG;
            ADDR_UNLOCK: next_unlock = rif.wdata & MASK_UNLOCK;
            ADDR_LANE_EN: next_lane_en = rif.wdata & MASK_LANE_EN;
            ADDR_CLK_CFG: next_clk_cfg = rif.wdata & MASK_CLK_CFG;
            ADDR_EVT_CFG: next_evt_cfg = rif.wdata & MASK_EVT_CFG;
            ADDR_ERR_MON: next_err_mon = rif.wdata & MASK_ERR_MON;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         dev_cfg <= RST_ZERO;
         unlock <= RST_ZERO;
         lane_en <= RST_ZERO; // R6
         clk_cfg <= RST_CLK_CFG; // R7
         evt_cfg <= RST_ZERO; // R13
         err_mon <= RST_ZERO;
      end else begin
         dev_cfg <= next_dev_cfg;
         unlock <= next_unlock;
         lane_en <= next_lane_en;
         clk_cfg <= next_clk_cfg;
         evt_cfg <= next_evt_cfg;
         err_mon <= next_err_mon;
      end
   end

   // ************************************************************
   // event counters
   // ************************************************************
   logic [EVT_W-1:0] evt_cnt [2];
   logic [1:0] evt_hit, evt_clr;

   assign evt_hit = {data_event, recovery_event};
   assign evt_clr = {evt_cfg[EVT_RST_DATA], evt_cfg[EVT_RST_REC]};

   // index 0 recovery, index 1 data; counters saturate so a long
   // fault never wraps back to a small, reassuring number
   for (genvar i = 0; i < 2; i++) begin : g_evt
      logic [EVT_W-1:0] next_cnt;
      always_comb begin
         next_cnt = evt_cnt[i];
         if (evt_clr[i]) begin
            next_cnt = '0; // R11 R12 R18
         end else if (evt_cfg[EVT_EN] && evt_hit[i] && !(&evt_cnt[i])) begin
            next_cnt = evt_cnt[i] + {{(EVT_W-1){1'b0}}, 1'b1}; // R13
         end
      end
      always_ff @(posedge clock) begin
         if (!resetn) begin
            evt_cnt[i] <= '0;
         end else begin
            evt_cnt[i] <= next_cnt;
         end
      end
   end

   // ************************************************************
   // error monitor
   // ************************************************************
   logic [ERR_W-1:0] err_cur, err_prev, next_err_cur, next_err_prev, err_bump;
   logic err_counted;

   assign err_counted = data_error | (decode_error & ~err_mon[ERR_DEC_DIS]); // R15
   assign err_bump = (err_counted && !(&err_cur)) ?
                     err_cur + {{(ERR_W-1){1'b0}}, 1'b1} : err_cur;

   // window end moves the run total to previous; clear wins over all
   always_comb begin
      next_err_cur = err_bump;
      next_err_prev = err_prev;
      if (err_mon[ERR_CLR]) begin
         next_err_cur = '0; // R16 R18
         next_err_prev = '0; // R16
      end else if (window_end) begin
         next_err_prev = err_bump;
         next_err_cur = err_mon[ERR_ACC] ? err_bump : '0; // R14
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         err_cur <= '0;
         err_prev <= '0;
      end else begin
         err_cur <= next_err_cur;
         err_prev <= next_err_prev;
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   logic next_nrzi, next_descr, next_mux, next_byp, next_train;
   logic [1:0] next_link, next_dly;
   logic [5:0] next_drv;
   logic next_vod, next_blk_rst, next_rate, next_inv, next_flag;
   logic [EVT_W-1:0] next_event_count;
   logic [ERR_W-1:0] next_error_count;

   // locked fields fall back to their reset value of zero
   always_comb begin
      next_nrzi = unlock[UNL_NRZI] & dev_cfg[CFG_NRZI]; // R1 R4
      next_descr = unlock[UNL_DESCR] & dev_cfg[CFG_DESCR]; // R1 R4
      next_mux = unlock[UNL_MUX] & dev_cfg[CFG_MUX]; // R1 R4
      next_byp = unlock[UNL_BYP] & dev_cfg[CFG_BYP]; // R2 R4
      next_train = unlock[UNL_TRAIN] & dev_cfg[CFG_TRAIN]; // R2 R4
      next_link = unlock[UNL_LINK] ? dev_cfg[CFG_LINK_HI:CFG_LINK_LO] : 2'h0; // R3
      next_drv = lane_en[LANE_CTRL] ? lane_en[LANE_CLK:0] : default_lane_enable; // R5 R6
      next_vod = lane_en[LANE_VOD];
      next_blk_rst = clk_cfg[CLK_RST];
      next_rate = clk_cfg[CLK_RATE]; // R7
      next_inv = clk_cfg[CLK_INV]; // R8
      next_dly = clk_cfg[CLK_DLY_HI:CLK_DLY_LO]; // R9
      next_event_count = evt_cfg[EVT_SEL] ? evt_cnt[1] : evt_cnt[0]; // R10
      next_error_count = err_mon[ERR_SEL] ? err_prev : err_cur; // R17
      next_flag = decode_error & ~err_mon[ERR_DEC_DIS]; // R15
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         nrzi_decode_en <= 1'b0;
         descramble_en <= 1'b0;
         input_select <= 1'b0;
         decoder_bypass <= 1'b0;
         training_en <= 1'b0;
         link_config <= 2'h0;
         {forwarded_clock_out_en, parallel_lane_out_en} <= 6'h00;
         output_vod_high <= 1'b0;
         output_block_reset <= 1'b0;
         forwarded_clock_full_rate <= RST_CLK_CFG[CLK_RATE];
         forwarded_clock_invert <= 1'b0;
         forwarded_clock_delay <= RST_CLK_CFG[CLK_DLY_HI:CLK_DLY_LO];
         event_count <= '0;
         error_count <= '0;
         lock_decode_flag <= 1'b0;
      end else begin
         nrzi_decode_en <= next_nrzi;
         descramble_en <= next_descr;
         input_select <= next_mux;
         decoder_bypass <= next_byp;
         training_en <= next_train;
         link_config <= next_link;
         {forwarded_clock_out_en, parallel_lane_out_en} <= next_drv;
         output_vod_high <= next_vod;
         output_block_reset <= next_blk_rst;
         forwarded_clock_full_rate <= next_rate;
         forwarded_clock_invert <= next_inv;
         forwarded_clock_delay <= next_dly;
         event_count <= next_event_count;
         error_count <= next_error_count;
         lock_decode_flag <= next_flag;
      end
   end

   // ************************************************************
   // readback
   // ************************************************************
   // counts read live; a 16-bit count read as two bytes may tear
   always_comb begin
      case (rif.addr)
         ADDR_DEV_CFG: rif.rdata = dev_cfg;
         ADDR_UNLOCK: rif.rdata = unlock;
         ADDR_LANE_EN: rif.rdata = lane_en;
         ADDR_CLK_CFG: rif.rdata = clk_cfg;
         ADDR_EVT_CFG: rif.rdata = evt_cfg;
         ADDR_ERR_MON: rif.rdata = err_mon;
         ADDR_EVT_STAT: rif.rdata = event_count[7:0];
         ADDR_ERR_LSB: rif.rdata = error_count[7:0];
         ADDR_ERR_MSB: rif.rdata = error_count[15:8];
         default: rif.rdata = 8'h00;
      endcase
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   nrzi_gate_a: assert property ( // R1
      !unlock[UNL_NRZI] |=> !nrzi_decode_en)
      else $error("decode enable passed while locked");
   bypass_gate_a: assert property ( // R2
      ##1 decoder_bypass == $past(unlock[UNL_BYP] && dev_cfg[CFG_BYP]))
      else $error("bypass does not follow its unlock");
   link_gate_a: assert property ( // R3
      !unlock[UNL_LINK] |=> link_config == 2'h0)
      else $error("link configuration passed while locked");
   mux_ignore_a: assert property ( // R4
      (rif.wr && rif.addr == ADDR_DEV_CFG && !unlock[UNL_MUX]) |=> ##1 !input_select)
      else $error("input select honoured while locked");
   lane_default_a: assert property ( // R5
      !lane_en[LANE_CTRL] |=>
      {forwarded_clock_out_en, parallel_lane_out_en} == $past(default_lane_enable))
      else $error("lane enables ignore default control");
   lane_map_a: assert property ( // R6
      lane_en[LANE_CTRL] |=> forwarded_clock_out_en == $past(lane_en[LANE_CLK])
      && parallel_lane_out_en == $past(lane_en[4:0]))
      else $error("lane enable mapping wrong");
   clk_rate_a: assert property ( // R7
      (rif.wr && rif.addr == ADDR_CLK_CFG && !rif.wdata[CLK_RATE]) |=> ##1
      !forwarded_clock_full_rate)
      else $error("clock rate not written");
   clk_invert_a: assert property ( // R8
      (rif.wr && rif.addr == ADDR_CLK_CFG && rif.wdata[CLK_INV]) |=> ##1
      forwarded_clock_invert)
      else $error("clock invert not applied");
   clk_delay_a: assert property ( // R9
      (rif.wr && rif.addr == ADDR_CLK_CFG) |=> ##1
      forwarded_clock_delay == $past(rif.wdata[CLK_DLY_HI:CLK_DLY_LO], 2))
      else $error("clock delay code wrong");
   evt_select_a: assert property ( // R10
      evt_cfg[EVT_SEL] |=> event_count == $past(evt_cnt[1]))
      else $error("data counter not selected");
   rec_reset_a: assert property ( // R11
      evt_cfg[EVT_RST_REC] |=> evt_cnt[0] == '0)
      else $error("recovery count not reset");
   data_reset_a: assert property ( // R12
      evt_cfg[EVT_RST_DATA] |=> evt_cnt[1] == '0)
      else $error("data count not reset");
   count_idle_a: assert property ( // R13
      !evt_cfg[EVT_EN] |=> $stable(evt_cnt[0]) || evt_cnt[0] == '0)
      else $error("counter moved while disabled");
   err_accum_a: assert property ( // R14
      (window_end && err_mon[ERR_ACC] && !err_mon[ERR_CLR] && !err_counted)
      |=> $stable(err_cur))
      else $error("accumulated count restarted");
   dec_exclude_a: assert property ( // R15
      (err_mon[ERR_DEC_DIS] && !data_error && !window_end && !err_mon[ERR_CLR])
      |=> $stable(err_cur) && !lock_decode_flag)
      else $error("excluded decode error counted");
   err_clear_a: assert property ( // R16
      err_mon[ERR_CLR] |=> err_cur == '0 && err_prev == '0)
      else $error("error counts not cleared");
   err_select_a: assert property ( // R17
      !err_mon[ERR_SEL] |=> error_count == $past(err_cur))
      else $error("current run count not reported");
   clear_resume_a: assert property ( // R18
      evt_cfg[EVT_RST_DATA] ##1 !evt_cfg[EVT_RST_DATA] |-> evt_cnt[1] == '0)
      else $error("count did not resume from zero");

   unlock_use_c: cover property (unlock[UNL_NRZI] ##1 nrzi_decode_en);
   lane_ctrl_c: cover property (lane_en[LANE_CTRL] && lane_en[LANE_CLK]);
   evt_count_c: cover property (evt_cfg[EVT_EN] && recovery_event ##1 evt_cnt[0] != '0);
   err_window_c: cover property (window_end && err_mon[ERR_ACC] && err_counted);
endmodule

/* File: testbench/dlec_smb_host.sv */
// SMBus host model driving the register bank pins
// assumes the bench builds a pulled-up SDA wire from both enables
module dlec_smb_host #(
   parameter logic [6:0] SLAVE_ADDR = 7'h5A
) (
   // clock and pins
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // 8-clock phases stay well above the 2-clock filter minimum
   task automatic ph();
      repeat (8) @(posedge clock);
      #2;
   endtask
   // one bit; a one releases SDA so the slave may drive it
   task automatic bit_io(input logic b, output logic s);
      sda_oe = !b;
      ph();
      scl = 1'b1;
      ph();
      s = sda;
      scl = 1'b0;
      ph();
   endtask
   // also serves as repeated start, since SCL is low between bytes
   task automatic start();
      sda_oe = 1'b0;
      ph();
      scl = 1'b1;
      ph();
      sda_oe = 1'b1;
      ph();
      scl = 1'b0;
      ph();
   endtask
   task automatic xfer(input logic [7:0] v, output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
      bit_io(1'b1, a);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({SLAVE_ADDR, 1'b0}, r);
      xfer(a, r);
      xfer(d, r);
      sda_oe = 1'b1;
      ph();
      scl = 1'b1;
      ph();
      sda_oe = 1'b0;
      ph();
   endtask
   // read ends with a master NACK then stop
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      start();
      xfer({SLAVE_ADDR, 1'b0}, r);
      xfer(a, r);
      start();
      xfer({SLAVE_ADDR, 1'b1}, r);
      xfer(8'hFF, d);
      wr_stop();
   endtask
   task automatic wr_stop();
      sda_oe = 1'b1;
      ph();
      scl = 1'b1;
      ph();
      sda_oe = 1'b0;
      ph();
   endtask
endmodule

/* File: testbench/dlec_regs_tb_top.sv */
// self-checking bench for the register bank over SMBus pins
// assumes the host model and a 40 MHz clock
module dlec_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dlec_pkg::*;
   logic clock, resetn, scl, h_oe, d_oe, rec, dat, derr, dec, wend;
   logic [5:0] dfl;
   logic [7:0] v, d;
   logic [6:0] cfg;
   logic [4:0] lane, ck;
   logic [7:0] evc;
   logic [15:0] erc;
   logic flag;
   int n_errors = 0, checks_done = 0, cyc = 0, n, seed, nflag = 0;
   wire sda = !(h_oe | d_oe);
   dlec_smb_host dlec_smb_host_i (.clock(clock), .sda(sda), .scl(scl), .sda_oe(h_oe));
   dlec_regs dlec_regs_i (.clock(clock), .resetn(resetn), .smb_scl_in(scl),
      .smb_sda_in(sda), .smb_sda_out(v[2]), .smb_sda_oe(d_oe), .nrzi_decode_en(cfg[6]),
      .descramble_en(cfg[5]), .input_select(cfg[4]), .decoder_bypass(cfg[3]),
      .training_en(cfg[2]), .link_config(cfg[1:0]), .default_lane_enable(dfl),
      .forwarded_clock_out_en(lane[4]), .parallel_lane_out_en({lane[3:0], v[0]}),
      .output_vod_high(v[1]), .output_block_reset(ck[4]), .forwarded_clock_full_rate(ck[3]),
      .forwarded_clock_invert(ck[2]), .forwarded_clock_delay(ck[1:0]),
      .recovery_event(rec), .data_event(dat), .event_count(evc), .data_error(derr),
      .decode_error(dec), .window_end(wend), .error_count(erc), .lock_decode_flag(flag));
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      dlec_smb_host_i.rd(a, d);
      chk("readback", e, d);
   endtask
   task automatic st();
      repeat (6) @(posedge clock);
      #2;
   endtask
   task automatic pulse(ref logic s, input int k);
      repeat (k) begin
         @(posedge clock);
         #2 s = 1'b1;
         @(posedge clock);
         #2 s = 1'b0;
      end
      st();
   endtask
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // clock and hang guard
   initial begin
      clock = 1'b0;
      forever #12.5 clock = !clock;
   end
   always @(posedge clock) begin
      cyc++;
      // the lock flag is a one-cycle pulse, so count it as it passes
      if (flag === 1'b1) nflag++;
      if (cyc == 90000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      seed = 32'h4ADF37F7;
      {resetn, rec, dat, derr, dec, wend} = 6'h00;
      dfl = 6'($random(seed));
      repeat (4) @(posedge clock);
      #2 resetn = 1'b1;
      st();
      chk("clk cfg", 6'h0A, {v[2], ck});
      rchk(ADDR_CLK_CFG, RST_CLK_CFG);
      rchk(ADDR_LANE_EN, RST_ZERO);
      rchk(8'h30, 8'h00);
      dlec_smb_host_i.wr(ADDR_DEV_CFG, 8'h7F);
      st();
      chk("locked", 7'h00, cfg);
      dlec_smb_host_i.wr(ADDR_UNLOCK, 8'h77);
      st();
      chk("unlocked", 7'h7F, cfg);
      n = $random(seed) & 8'hBF;
      dlec_smb_host_i.wr(ADDR_LANE_EN, n[7:0]);
      st();
      chk("default lanes", dfl, {lane, v[0]});
      dlec_smb_host_i.wr(ADDR_LANE_EN, n[7:0] | 8'h40);
      st();
      chk("bus lanes", {n[7], n[5:0]}, {v[1], lane, v[0]});
      n = $random(seed) & MASK_CLK_CFG;
      dlec_smb_host_i.wr(ADDR_CLK_CFG, n[7:0]);
      st();
      chk("clk cfg", n[6:2], ck);
      n = ($random(seed) & 7) + 1;
      pulse(rec, n);
      chk("idle", 0, evc);
      dlec_smb_host_i.wr(ADDR_EVT_CFG, 8'h01);
      pulse(rec, n);
      pulse(dat, 2);
      chk("recovery", n, evc);
      dlec_smb_host_i.wr(ADDR_EVT_CFG, 8'h0B);
      pulse(dat, 1);
      chk("data held", 0, evc);
      dlec_smb_host_i.wr(ADDR_EVT_CFG, 8'h09);
      pulse(dat, 1);
      chk("data resumed", 1, evc);
      dlec_smb_host_i.wr(ADDR_EVT_CFG, 8'h05);
      st();
      chk("recovery held", 0, evc);
      pulse(derr, n);
      dlec_smb_host_i.wr(ADDR_ERR_MON, 8'h08);
      pulse(dec, 1);
      chk("decode dropped", n, erc);
      chk("flag dropped", 0, nflag);
      dlec_smb_host_i.wr(ADDR_ERR_MON, 8'h12);
      pulse(dec, 1);
      pulse(wend, 2);
      chk("window", n + 1, erc);
      chk("flag raised", 1, nflag);
      dlec_smb_host_i.wr(ADDR_ERR_MON, 8'h16);
      st();
      chk("cleared", 0, erc);
      tally_and_finish();
   end
endmodule
